// *** pkg/acq_pkg.sv ***
`default_nettype none
package acq_pkg;
	// Bus and structure sizes
	localparam int ACQ_AW = 8;
	localparam int ACQ_DW = 32;
	localparam int ACQ_NTERM = 4;
	localparam int ACQ_NSRC = 8;
	localparam int ACQ_NSTREAM = 4;
	localparam int ACQ_SELW = 3;
	localparam int ACQ_FLW = 8;

	// Register offsets (byte addresses, one word each)
	localparam logic [7:0] ACQ_CTRL = 8'h00;
	localparam logic [7:0] ACQ_START_SEL = 8'h04;
	localparam logic [7:0] ACQ_REF_SEL = 8'h08;
	localparam logic [7:0] ACQ_HOLD_SEL = 8'h0C;
	localparam logic [7:0] ACQ_COUNT = 8'h10;
	localparam logic [7:0] ACQ_DELAY = 8'h14;
	localparam logic [7:0] ACQ_RATE = 8'h18;
	localparam logic [7:0] ACQ_FILTER = 8'h1C;
	localparam logic [7:0] ACQ_STATUS = 8'h20;
	localparam logic [7:0] ACQ_TAKEN = 8'h24;

	// Control register field positions
	localparam int CTRL_SW_START = 0;
	localparam int CTRL_SW_STOP = 1;
	localparam int CTRL_CONT = 2;
	localparam int CTRL_REF = 3;
	localparam int CTRL_SRC_LO = 4;
	localparam int CTRL_FALL = 6;
	localparam int CTRL_ROUTE = 7;
	localparam int CTRL_MASK_LO = 8;
	// Source select / filter / status field positions
	localparam int SEL_EDGE = 3;
	localparam int HOLD_EN = 4;
	localparam int FILT_LEN_LO = 8;
	localparam int STAT_DONE = 2;
	localparam int STAT_GRANT_LO = 4;

	// Start source encodings
	localparam logic [1:0] SRC_NONE = 2'h0;
	localparam logic [1:0] SRC_DIG = 2'h1;
	localparam logic [1:0] SRC_ANA = 2'h2;

	// Values after reset
	localparam logic [31:0] RATE_RST = 32'h00000064;
	localparam logic [31:0] COUNT_RST = 32'h00000001;
	localparam logic [7:0] FILT_LEN_RST = 8'h04;

	typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN} acq_state_t;
endpackage
`default_nettype wire

// *** hw/acq_line_filter.sv ***
`timescale 1ns/1ps
`default_nettype none
module acq_line_filter (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Line and settings
	input wire logic line_sync,
	input wire logic filt_on,
	input wire logic [acq_pkg::ACQ_FLW-1:0] filt_len,
	// Cleaned level
	output logic line_clean
);
	import acq_pkg::*;

	logic [ACQ_FLW-1:0] stable_cnt;

	// With filt_on set, a change passes only after it has held for filt_len + 1 cycles
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			line_clean <= 1'b0;
			stable_cnt <= '0;
		end else if (!filt_on || line_sync == line_clean) begin
			line_clean <= line_sync;
			stable_cnt <= '0;
		end else if (stable_cnt >= filt_len) begin
			line_clean <= line_sync;
			stable_cnt <= '0;
		end else begin
			stable_cnt <= stable_cnt + 8'h01;
		end
	end
endmodule
`default_nettype wire

// *** hw/acq_rate_gen.sv ***
`timescale 1ns/1ps
`default_nettype none
module acq_rate_gen (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Control
	input wire logic run,
	input wire logic hold,
	input wire logic [31:0] first_delay,
	input wire logic [31:0] period,
	// One-cycle sample tick
	output logic tick
);
	import acq_pkg::*;

	logic [31:0] cnt;

	// Delay is loaded while stopped, so the first tick trails the start
	// by first_delay + 1 cycles; a period of zero behaves as one
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt <= '0;
			tick <= 1'b0;
		end else if (!run) begin
			cnt <= first_delay;
			tick <= 1'b0;
		end else if (hold) begin
			tick <= 1'b0;
		end else if (cnt == 32'h00000000) begin
			cnt <= (period == 32'h00000000) ? 32'h00000000 : period - 32'h1;
			tick <= 1'b1;
		end else begin
			cnt <= cnt - 32'h1;
			tick <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// *** hw/acq_trigger_ctrl.sv ***
// Notes on behaviour
// - One timing engine: a start while armed or running is ignored.
// - No trigger source means software start begins; otherwise trigger begins it.
// - Finite mode stops itself after the programmed number of samples.
// - Finite mode may instead stop on a reference trigger edge.
// - Continuous mode runs until a software stop; no count ends it.
// - No sample is taken before the start event.
// - A programmable delay separates start event and first sample.
// - Digital start source is chosen from terminals, counters or internal signals.
// - Digital start fires on rising or falling edge, as configured.
// - Analog comparison start fires on its first rising edge.
// - Start trigger can be routed to terminals as an active-high pulse.
// - Start, reference and hold sources are selected independently.
// - Every terminal input has its own enableable noise filter.
// - Four data streams; acquisition claims a free one while it runs.
// - Each sample clock pulse marks one sample of all channels.
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module acq_trigger_ctrl (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Register port
	input wire logic [acq_pkg::ACQ_AW-1:0] reg_addr,
	input wire logic [acq_pkg::ACQ_DW-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [acq_pkg::ACQ_DW-1:0] reg_rdata,
	// Programmable function terminal pins
	input wire logic [acq_pkg::ACQ_NTERM-1:0] pft_in,
	output logic [acq_pkg::ACQ_NTERM-1:0] pft_out,
	output logic [acq_pkg::ACQ_NTERM-1:0] pft_oe,
	// Internal trigger sources (same clock)
	input wire logic [1:0] ctr_out,
	input wire logic [1:0] int_trig,
	// Analog comparison event from an input module
	input wire logic ana_cmp_event,
	// Data stream allocation
	input wire logic [acq_pkg::ACQ_NSTREAM-1:0] stream_busy,
	output logic [acq_pkg::ACQ_NSTREAM-1:0] stream_grant,
	// Acquisition timing
	output logic acq_sample_clock,
	output logic acq_active
);
	import acq_pkg::*;

	acq_state_t state;
	acq_state_t next_state;

	// Configuration
	logic mode_cont, mode_ref, start_fall, route_en;
	logic [1:0] start_src;
	logic [ACQ_NTERM-1:0] route_mask;
	logic [ACQ_SELW-1:0] start_sel, ref_sel, hold_sel;
	logic ref_fall, hold_low, hold_on;
	logic [31:0] sample_count, start_delay, sample_rate, taken;
	logic [ACQ_NTERM-1:0] filt_en;
	logic [ACQ_FLW-1:0] filt_len;
	logic done;

	// Source conditioning
	logic [ACQ_NTERM-1:0] pft_meta, pft_sync, pft_clean;
	logic ana_meta, ana_sync, ana_prev;
	logic [ACQ_NSRC-1:0] src_vec;
	logic dig_now, dig_prev, ref_now, ref_prev, hold_now;
	logic dig_edge, ana_rise, ref_edge, start_fire;
	logic sw_start, sw_stop, count_hit, sample_tick, sample_ok;
	logic [ACQ_NSTREAM-1:0] stream_free, stream_pick;

	// Two flops on every pin, then a per-line filter
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pft_meta <= '0;
			pft_sync <= '0;
			ana_meta <= 1'b0;
			ana_sync <= 1'b0;
		end else begin
			pft_meta <= pft_in;
			pft_sync <= pft_meta;
			ana_meta <= ana_cmp_event;
			ana_sync <= ana_meta;
		end
	end

	for (genvar gi = 0; gi < ACQ_NTERM; gi++) begin : g_filt
		acq_line_filter u_filt (
			.core_clk(core_clk),
			.reset_n(reset_n),
			.line_sync(pft_sync[gi]),
			.filt_on(filt_en[gi]),
			.filt_len(filt_len),
			.line_clean(pft_clean[gi])
		);
	end

	// Source menu: terminals, counter outputs, internal signals
	assign src_vec = {int_trig, ctr_out, pft_clean};
	assign dig_now = src_vec[start_sel];
	assign ref_now = src_vec[ref_sel];
	assign hold_now = hold_on && (src_vec[hold_sel] ^ hold_low);

	// Previous levels for edge detection
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			dig_prev <= 1'b0;
			ref_prev <= 1'b0;
			ana_prev <= 1'b0;
		end else begin
			dig_prev <= dig_now;
			ref_prev <= ref_now;
			ana_prev <= ana_sync;
		end
	end

	assign dig_edge = start_fall ? (dig_prev && !dig_now)
		: (!dig_prev && dig_now);
	assign ana_rise = !ana_prev && ana_sync;
	assign ref_edge = ref_fall ? (ref_prev && !ref_now)
		: (!ref_prev && ref_now);

	// Software commands are write-one pulses in the control word
	assign sw_start = reg_write && reg_addr == ACQ_CTRL
		&& reg_wdata[CTRL_SW_START];
	assign sw_stop = reg_write && reg_addr == ACQ_CTRL
		&& reg_wdata[CTRL_SW_STOP];

	// Lowest free stream; waiting for one keeps the task armed
	assign stream_free = ~stream_busy;
	assign stream_pick = stream_free & (~stream_free + 4'h1);

	// One qualified start per armed period; edges while running are ignored
	always_comb begin
		start_fire = 1'b0;
		if (state == ST_ARMED && stream_free != 4'h0) begin
			case (start_src)
				SRC_NONE: start_fire = 1'b1;
				SRC_DIG: start_fire = dig_edge;
				SRC_ANA: start_fire = ana_rise;
				default: start_fire = 1'b0;
			endcase
		end
	end

	// Rate generator: delay to first sample, paused by the hold trigger
	acq_rate_gen u_rate (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.run(state == ST_RUN),
		.hold(hold_now),
		.first_delay(start_delay),
		.period(sample_rate),
		.tick(sample_tick)
	);

	assign sample_ok = sample_tick && state == ST_RUN;
	assign count_hit = !mode_cont && !mode_ref && sample_ok
		&& taken + 32'h1 >= sample_count;

	// Control state machine
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: if (sw_start) next_state = ST_ARMED;
			ST_ARMED: begin
				if (sw_stop) next_state = ST_IDLE;
				else if (start_fire) next_state = ST_RUN;
			end
			ST_RUN: begin
				if (sw_stop) next_state = ST_IDLE;
				else if (count_hit) next_state = ST_IDLE;
				else if (mode_ref && !mode_cont && ref_edge)
					next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase
	end

	// State register; a second start is absorbed while busy
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) state <= ST_IDLE;
		else state <= next_state;
	end

	// Stream claim held for the run
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) stream_grant <= '0;
		else if (start_fire) stream_grant <= stream_pick;
		else if (next_state != ST_RUN) stream_grant <= '0;
	end

	// Sample counter and sample clock pulse
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			taken <= '0;
			acq_sample_clock <= 1'b0;
		end else begin
			acq_sample_clock <= sample_ok;
			if (start_fire) taken <= '0;
			else if (sample_ok) taken <= taken + 32'h1;
		end
	end

	// Done flag: hardware end sets it, a new start clears it; set wins
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) done <= 1'b0;
		else if (state == ST_RUN && next_state == ST_IDLE && !sw_stop)
			done <= 1'b1;
		else if (sw_start) done <= 1'b0;
	end

	assign acq_active = (state == ST_RUN);

	// Routed start pulse; enables stay on so the pin idles low
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pft_out <= '0;
			pft_oe <= '0;
		end else begin
			pft_oe <= route_en ? route_mask : 4'h0;
			pft_out <= (route_en && start_fire) ? route_mask : 4'h0;
		end
	end

	// Register writes
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			mode_cont <= 1'b0;
			mode_ref <= 1'b0;
			start_src <= SRC_NONE;
			start_fall <= 1'b0;
			route_en <= 1'b0;
			route_mask <= '0;
			start_sel <= '0;
			ref_sel <= '0;
			ref_fall <= 1'b0;
			hold_sel <= '0;
			hold_low <= 1'b0;
			hold_on <= 1'b0;
			sample_count <= COUNT_RST;
			start_delay <= '0;
			sample_rate <= RATE_RST;
			filt_en <= '0;
			filt_len <= FILT_LEN_RST;
		end else if (reg_write) begin
			case (reg_addr)
				ACQ_CTRL: begin
					mode_cont <= reg_wdata[CTRL_CONT];
					mode_ref <= reg_wdata[CTRL_REF];
					start_src <= reg_wdata[CTRL_SRC_LO +: 2];
					start_fall <= reg_wdata[CTRL_FALL];
					route_en <= reg_wdata[CTRL_ROUTE];
					route_mask <= reg_wdata[CTRL_MASK_LO +: ACQ_NTERM];
				end
				ACQ_START_SEL: start_sel <= reg_wdata[ACQ_SELW-1:0];
				ACQ_REF_SEL: begin
					ref_sel <= reg_wdata[ACQ_SELW-1:0];
					ref_fall <= reg_wdata[SEL_EDGE];
				end
				ACQ_HOLD_SEL: begin
					hold_sel <= reg_wdata[ACQ_SELW-1:0];
					hold_low <= reg_wdata[SEL_EDGE];
					hold_on <= reg_wdata[HOLD_EN];
				end
				ACQ_COUNT: sample_count <= reg_wdata;
				ACQ_DELAY: start_delay <= reg_wdata;
				ACQ_RATE: sample_rate <= reg_wdata;
				ACQ_FILTER: begin
					filt_en <= reg_wdata[ACQ_NTERM-1:0];
					filt_len <= reg_wdata[FILT_LEN_LO +: ACQ_FLW];
				end
				default: ;
			endcase
		end
	end

	// Read data one cycle after the strobe, zero otherwise
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) reg_rdata <= '0;
		else if (!reg_read) reg_rdata <= '0;
		else begin
			case (reg_addr)
				ACQ_CTRL: reg_rdata <= {20'h0, route_mask, route_en,
					start_fall, start_src, mode_ref, mode_cont, 2'h0};
				ACQ_START_SEL: reg_rdata <= {29'h0, start_sel};
				ACQ_REF_SEL: reg_rdata <= {28'h0, ref_fall, ref_sel};
				ACQ_HOLD_SEL: reg_rdata <= {27'h0, hold_on, hold_low,
					hold_sel};
				ACQ_COUNT: reg_rdata <= sample_count;
				ACQ_DELAY: reg_rdata <= start_delay;
				ACQ_RATE: reg_rdata <= sample_rate;
				ACQ_FILTER: reg_rdata <= {16'h0, filt_len, 4'h0, filt_en};
				ACQ_STATUS: reg_rdata <= {24'h0, stream_grant, 1'b0,
					done, state};
				ACQ_TAKEN: reg_rdata <= taken;
				default: reg_rdata <= '0;
			endcase
		end
	end

	// Checks
	property p_one_engine;
		@(posedge core_clk) disable iff (!reset_n)
		(state == ST_RUN && sw_start && !sw_stop && !count_hit
			&& !(mode_ref && ref_edge)) |=> state == ST_RUN;
	endproperty
	a_one_engine: assert property (p_one_engine)
		else $error("start accepted while running");
	property p_sw_start;
		@(posedge core_clk) disable iff (!reset_n)
		(state == ST_IDLE && sw_start && stream_busy != 4'hF
			&& reg_wdata[CTRL_SRC_LO +: 2] == SRC_NONE)
			##1 (stream_busy != 4'hF && !sw_stop)
			|=> state == ST_RUN;
	endproperty
	a_sw_start: assert property (p_sw_start)
		else $error("software start did not begin acquisition");
	property p_count_stop;
		@(posedge core_clk) disable iff (!reset_n)
		(count_hit && !sw_stop) |=> state == ST_IDLE && done;
	endproperty
	a_count_stop: assert property (p_count_stop)
		else $error("finite count did not end acquisition");
	property p_ref_stop;
		@(posedge core_clk) disable iff (!reset_n)
		(state == ST_RUN && mode_ref && !mode_cont && ref_edge)
			|=> state == ST_IDLE;
	endproperty
	a_ref_stop: assert property (p_ref_stop)
		else $error("reference trigger did not stop acquisition");
	property p_cont_run;
		@(posedge core_clk) disable iff (!reset_n)
		(state == ST_RUN && mode_cont && !sw_stop) |=> state == ST_RUN;
	endproperty
	a_cont_run: assert property (p_cont_run)
		else $error("continuous acquisition ended without stop");
	property p_no_early;
		@(posedge core_clk) disable iff (!reset_n)
		acq_sample_clock |-> $past(state) == ST_RUN;
	endproperty
	a_no_early: assert property (p_no_early)
		else $error("sample taken outside a run");
	property p_dig_edge;
		@(posedge core_clk) disable iff (!reset_n)
		(state == ST_ARMED && start_src == SRC_DIG && stream_busy != 4'hF
			&& !sw_stop && (start_fall ? $fell(dig_now) : $rose(dig_now)))
			|=> state == ST_RUN ##0 acq_active;
	endproperty
	a_dig_edge: assert property (p_dig_edge)
		else $error("digital start edge missed");
	property p_route;
		@(posedge core_clk) disable iff (!reset_n)
		(start_fire && route_en && route_mask != 4'h0) |=>
			(pft_out == $past(route_mask)) ##1 pft_out == 4'h0;
	endproperty
	a_route: assert property (p_route)
		else $error("routed start pulse wrong");
	property p_count_tick;
		@(posedge core_clk) disable iff (!reset_n)
		(sample_ok && !start_fire) |=> taken == $past(taken) + 32'h1;
	endproperty
	a_count_tick: assert property (p_count_tick)
		else $error("sample not counted");
endmodule
`default_nettype wire

// *** tb/acq_src_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module acq_src_model (
	// Clock
	input wire logic core_clk,
	// Levels the bench asks the far side to show
	input wire logic [3:0] want_pins,
	input wire logic want_ana,
	// Trigger lines toward the device
	output logic [3:0] pft_in,
	output logic ana_cmp_event
);
	// One driver per line; levels are unknown only until the first edge,
	// which the bench keeps inside reset.
	// Levels move one edge late, as a real module output would
	always @(posedge core_clk) begin
		pft_in <= want_pins;
		ana_cmp_event <= want_ana;
	end
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin \
	fail_count++; \
	$display("wrong value %s exp %0h got %0h", nm, ex, got); end end
module tb_top;
	import acq_pkg::*;
	typedef struct packed {logic w; logic [7:0] a; logic [31:0] d;} acq_row_t;
	logic core_clk;
	logic reset_n;
	logic reg_write;
	logic reg_read;
	logic ana_want;
	logic ana_cmp_event;
	logic acq_sample_clock;
	logic acq_active;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata;
	logic [31:0] reg_rdata;
	logic [31:0] rd_val;
	logic [3:0] pft_in;
	logic [3:0] pft_out;
	logic [3:0] pft_oe;
	logic [3:0] stream_busy;
	logic [3:0] stream_grant;
	logic [3:0] pin_want;
	logic [1:0] ctr_out;
	logic [1:0] int_trig;
	int fail_count;
	int tests_run;
	int samp_cnt;
	int cyc;
	int k;
	int base;
	// Reads carry their expected value in d; writes to 8'h40 and ACQ_TAKEN leave nothing behind
	acq_row_t rows [16] = '{
		'{1'h0, ACQ_RATE, 32'h00000064}, '{1'h0, ACQ_COUNT, 32'h00000001},
		'{1'h0, ACQ_FILTER, 32'h00000400}, '{1'h0, ACQ_STATUS, 32'h00000000},
		'{1'h0, ACQ_TAKEN, 32'h00000000}, '{1'h1, 8'h40, 32'hFFFFFFFF},
		'{1'h0, 8'h40, 32'h00000000}, '{1'h1, ACQ_DELAY, 32'h00000005},
		'{1'h0, ACQ_DELAY, 32'h00000005}, '{1'h1, ACQ_HOLD_SEL, 32'h0000000F},
		'{1'h0, ACQ_HOLD_SEL, 32'h0000000F}, '{1'h1, ACQ_CTRL, 32'h00000F84},
		'{1'h0, ACQ_CTRL, 32'h00000F84}, '{1'h1, ACQ_TAKEN, 32'h000000FF},
		'{1'h0, ACQ_TAKEN, 32'h00000000}, '{1'h1, ACQ_CTRL, 32'h00000000}};

	acq_trigger_ctrl i_acq_trigger_ctrl (.core_clk(core_clk),
		.reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.pft_in(pft_in), .pft_out(pft_out), .pft_oe(pft_oe),
		.ctr_out(ctr_out), .int_trig(int_trig),
		.ana_cmp_event(ana_cmp_event), .stream_busy(stream_busy),
		.stream_grant(stream_grant), .acq_sample_clock(acq_sample_clock),
		.acq_active(acq_active));

	acq_src_model i_acq_src_model (.core_clk(core_clk), .want_pins(pin_want),
		.want_ana(ana_want), .pft_in(pft_in), .ana_cmp_event(ana_cmp_event));

	initial begin
		core_clk = 1'h0;
		forever #5 core_clk = ~core_clk;
	end

	// Sample pulses are counted at the edge that sees them high
	always @(posedge core_clk) begin
		if (acq_sample_clock === 1'h1) samp_cnt++;
	end

	// Hang guard: every scenario together needs well under 2000 cycles
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			$display("timeout reached");
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'h1;
		@(posedge core_clk);
		reg_write <= 1'h0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_read <= 1'h1;
		@(posedge core_clk);
		reg_read <= 1'h0;
		#1 d = reg_rdata;
	endtask

	task automatic wait_act(input logic v);
		k = 0;
		while (acq_active !== v && k < 300) begin
			@(posedge core_clk);
			#1 k++;
		end
		`CHK("acq_active", v, acq_active)
	endtask

	task automatic to_sample(output int n);
		n = 0;
		do begin
			@(posedge core_clk);
			#1 n++;
		end while (acq_sample_clock !== 1'h1 && n < 400);
	endtask

	initial begin
		{reg_write, reg_read, ana_want} = 3'h0;
		reg_addr = 8'h00;
		reg_wdata = 32'h00000000;
		{ctr_out, int_trig} = 4'h0;
		stream_busy = 4'h1;
		pin_want = 4'hF;
		{fail_count, tests_run, samp_cnt, cyc} = 0;
		reset_n = 1'h0;
		repeat (3) @(posedge core_clk);
		`CHK("oe", 4'h0, pft_oe)
		`CHK("grant", 4'h0, stream_grant)
		reset_n <= 1'h1;
		for (int i = 0; i < 16; i++) begin
			if (rows[i].w) wr(rows[i].a, rows[i].d);
			else begin
				rd(rows[i].a, rd_val);
				`CHK("register", rows[i].d, rd_val)
			end
		end
		$display("test register table done");
		// Software start, finite count, routed pulse, one extra start ignored
		wr(ACQ_COUNT, 32'h00000003);
		wr(ACQ_RATE, 32'h00000008);
		wr(ACQ_CTRL, 32'h00000C81);
		base = samp_cnt;
		wait_act(1'h1);
		`CHK("pulse", 4'hC, pft_out)
		`CHK("oe", 4'hC, pft_oe)
		`CHK("free stream", 1'h1, (stream_grant & stream_busy) == 4'h0
			&& $onehot(stream_grant))
		`CHK("early samples", base, samp_cnt)
		to_sample(k);
		`CHK("first delay", 7, k)
		to_sample(k);
		`CHK("period", 8, k)
		wr(ACQ_CTRL, 32'h00000C81);
		wait_act(1'h0);
		// The last pulse rises with the stop and is counted an edge later
		repeat (2) @(posedge core_clk);
		`CHK("samples", base + 3, samp_cnt)
		rd(ACQ_TAKEN, rd_val);
		`CHK("taken", 32'h00000003, rd_val)
		rd(ACQ_STATUS, rd_val);
		`CHK("status", 32'h00000004, rd_val)
		$display("test software start done");
		// Digital falling edge on line 1, filtered, other line and glitch ignored
		wr(ACQ_FILTER, 32'h00000202);
		wr(ACQ_START_SEL, 32'h00000001);
		wr(ACQ_COUNT, 32'h00000001);
		wr(ACQ_DELAY, 32'h00000000);
		wr(ACQ_RATE, 32'h00000004);
		wr(ACQ_CTRL, 32'h00000051);
		rd(ACQ_STATUS, rd_val);
		`CHK("armed", 32'h00000001, rd_val)
		pin_want <= 4'hE;
		@(posedge core_clk);
		pin_want <= 4'hC;
		@(posedge core_clk);
		pin_want <= 4'hE;
		repeat (20) @(posedge core_clk);
		`CHK("glitch start", 1'h0, acq_active)
		pin_want <= 4'hC;
		wait_act(1'h1);
		wait_act(1'h0);
		repeat (20) @(posedge core_clk);
		rd(ACQ_STATUS, rd_val);
		`CHK("one start", 32'h00000004, rd_val)
		$display("test digital start done");
		// Analog start, continuous run, hold freezes the clock, soft stop
		pin_want <= 4'hF;
		wr(ACQ_HOLD_SEL, 32'h00000016);
		wr(ACQ_CTRL, 32'h00000025);
		repeat (10) @(posedge core_clk);
		`CHK("armed idle", 1'h0, acq_active)
		ana_want <= 1'h1;
		wait_act(1'h1);
		base = samp_cnt;
		repeat (60) @(posedge core_clk);
		`CHK("continuous", 1'h1, acq_active)
		`CHK("many samples", 1'h1, samp_cnt > base + 5)
		int_trig <= 2'h1;
		repeat (3) @(posedge core_clk);
		base = samp_cnt;
		repeat (40) @(posedge core_clk);
		`CHK("held", base, samp_cnt)
		int_trig <= 2'h0;
		ana_want <= 1'h0;
		wr(ACQ_CTRL, 32'h00000026);
		wait_act(1'h0);
		rd(ACQ_STATUS, rd_val);
		`CHK("stopped", 32'h00000000, rd_val)
		$display("test analog start done");
		// Reference trigger from a counter output ends a long finite run
		wr(ACQ_HOLD_SEL, 32'h00000000);
		wr(ACQ_REF_SEL, 32'h00000004);
		wr(ACQ_COUNT, 32'h000000FF);
		wr(ACQ_CTRL, 32'h00000009);
		wait_act(1'h1);
		repeat (20) @(posedge core_clk);
		ctr_out <= 2'h1;
		repeat (10) @(posedge core_clk);
		`CHK("ref stop", 1'h0, acq_active)
		rd(ACQ_STATUS, rd_val);
		`CHK("ref done", 32'h00000004, rd_val)
		ctr_out <= 2'h0;
		$display("test reference stop done");
		// Reset in the middle of a continuous routed run
		wr(ACQ_CTRL, 32'h00000F85);
		wait_act(1'h1);
		reset_n <= 1'h0;
		repeat (2) @(posedge core_clk);
		`CHK("reset run", 1'h0, acq_active)
		`CHK("reset oe", 4'h0, pft_oe)
		`CHK("reset grant", 4'h0, stream_grant)
		reset_n <= 1'h1;
		rd(ACQ_CTRL, rd_val);
		`CHK("reset ctrl", 32'h00000000, rd_val)
		$display("test reset done");
		wrap_up();
	end
endmodule
`default_nettype wire
